//--- common/dp_pkg.sv
// Shared types, constants and helpers of the data-processing unit.
// Assumes one clock domain and register access over AXI4-Lite.
package dp_pkg;

    // ----------------------------------------------------------------
    // Widths and indices
    // ----------------------------------------------------------------
    localparam int XLEN   = 32;
    localparam int NREG   = 16;
    localparam int AW     = 8;
    localparam int PC_LSB = 2;
    localparam int PC_MSB = 25;
    localparam int FLAG_N = 31;
    localparam int FLAG_Z = 30;
    localparam int FLAG_C = 29;
    localparam int FLAG_V = 28;

    localparam logic [3:0]  LINK_IDX  = 4'he;
    localparam logic [3:0]  PCS_IDX   = 4'hf;
    localparam logic [31:0] PC_MASK   = 32'h03fffffc;
    localparam logic [31:0] USER_MASK = 32'hf3fffffc;
    localparam logic [31:0] LINK_STEP = 32'h00000004;
    localparam logic [1:0]  MODE_USER = 2'h0;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [1:0] GPR_REGION  = 2'h0;
    localparam logic [7:0] OFF_INSTR   = 8'h40;
    localparam logic [7:0] OFF_CALL    = 8'h44;
    localparam logic [7:0] OFF_RESULT  = 8'h48;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        sum_op                   = 4'h0,
        sum_carry_op             = 4'h1,
        conjunction_op           = 4'h2,
        mask_clear_op            = 4'h3,
        compare_op               = 4'h4,
        compare_negated_op       = 4'h5,
        bitwise_xor_op           = 4'h6,
        copy_op                  = 4'h7,
        invert_copy_op           = 4'h8,
        bitwise_disjunction_op   = 4'h9,
        reversed_minus_op        = 4'ha,
        reversed_minus_borrow_op = 4'hb,
        minus_with_borrow_op     = 4'hc,
        minus_op                 = 4'hd,
        equivalence_test_op      = 4'he,
        mask_test_op             = 4'hf
    } alu_op_t;

    typedef enum logic [1:0] {
        sh_lsl = 2'h0,
        sh_lsr = 2'h1,
        sh_asr = 2'h2,
        sh_ror = 2'h3
    } sh_kind_t;

    // Immediate form: amt is the 8-bit constant, rm half the rotate count
    typedef struct packed {
        alu_op_t    op;
        logic       set_flags;
        logic [3:0] rd;
        logic [3:0] rn;
        logic [3:0] rm;
        sh_kind_t   sh;
        logic       amt_reg;
        logic       imm_form;
        logic [2:0] spare;
        logic [7:0] amt;
    } instr_t;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic op_is_arith(input alu_op_t op);
        return op inside {sum_op, sum_carry_op, compare_op,
                          compare_negated_op, reversed_minus_op,
                          reversed_minus_borrow_op,
                          minus_with_borrow_op, minus_op};
    endfunction

    function automatic logic op_has_dest(input alu_op_t op);
        return !(op inside {compare_op, compare_negated_op,
                            equivalence_test_op, mask_test_op});
    endfunction

    function automatic logic [31:0] byte_merge(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

endpackage

//--- hdl/barrel_shift.sv
// Barrel shifter feeding the second operand of the ALU.
// Assumes amount is already the register byte or the immediate count.
`timescale 1ns/1ps
`default_nettype none
module barrel_shift import dp_pkg::*; (
    input  wire logic [XLEN-1:0] val,
    input  wire sh_kind_t        kind,
    input  wire logic [7:0]      amt,
    input  wire logic            rrx,
    input  wire logic            cin,
    output logic      [XLEN-1:0] res,
    output logic                 cout
);
    // Wide shifts give the bit shifted out for free
    wire [2*XLEN-1:0] lsl_w = {{XLEN{1'b0}}, val} << amt;
    wire [2*XLEN-1:0] lsr_w = {val, {XLEN{1'b0}}} >> amt;
    wire [7:0]        asr_n = (amt > 8'h3f) ? 8'h3f : amt;
    wire [2*XLEN-1:0] asr_w = $signed({val, {XLEN{1'b0}}}) >>> asr_n;
    wire [4:0]        rot_n = amt[4:0];
    wire [5:0]        rot_b = 6'h20 - {1'b0, rot_n};
    wire [XLEN-1:0]   ror_w = (val >> rot_n) | (val << rot_b);

    always_comb begin
        res  = val;
        cout = cin;
        if (rrx) begin
            res  = {cin, val[XLEN-1:1]};
            cout = val[0];
        end else if (amt != 8'h00) begin
            unique case (kind)
                sh_lsl: begin
                    res  = lsl_w[XLEN-1:0];
                    cout = lsl_w[XLEN];
                end
                sh_lsr: begin
                    res  = lsr_w[2*XLEN-1:XLEN];
                    cout = lsr_w[XLEN-1];
                end
                sh_asr: begin
                    res  = asr_w[2*XLEN-1:XLEN];
                    cout = asr_w[XLEN-1];
                end
                sh_ror: begin
                    res  = ror_w;
                    cout = ror_w[XLEN-1];
                end
            endcase
        end
    end
endmodule // barrel_shift
`default_nettype wire

//--- hdl/alu_core.sv
// Combinational ALU: sixteen operations on a register and an operand.
// Assumes the operand has already passed the barrel shifter.
`timescale 1ns/1ps
`default_nettype none
module alu_core import dp_pkg::*; (
    input  wire alu_op_t         op,
    input  wire logic [XLEN-1:0] a,
    input  wire logic [XLEN-1:0] b,
    input  wire logic            cin,
    output logic      [XLEN-1:0] res,
    output logic                 c_out,
    output logic                 v_out
);
    logic [XLEN-1:0] lhs;
    logic [XLEN-1:0] rhs;
    logic            ci;

    always_comb begin
        lhs = a;
        rhs = b;
        ci  = 1'b0;
        unique case (op)
            sum_carry_op:             ci = cin;
            minus_op, compare_op:     begin rhs = ~b; ci = 1'b1; end
            minus_with_borrow_op:     begin rhs = ~b; ci = cin; end
            reversed_minus_op:        begin lhs = b; rhs = ~a; ci = 1'b1; end
            reversed_minus_borrow_op: begin lhs = b; rhs = ~a; ci = cin; end
            default: ;
        endcase
    end

    // Split at bit 31 to see the carry into the top bit
    wire [XLEN-1:0] lo = {1'b0, lhs[XLEN-2:0]} + {1'b0, rhs[XLEN-2:0]}
                         + {{(XLEN-1){1'b0}}, ci};
    wire [1:0]      hi = {1'b0, lhs[XLEN-1]} + {1'b0, rhs[XLEN-1]}
                         + {1'b0, lo[XLEN-1]};
    wire [XLEN-1:0] sum_w = {hi[0], lo[XLEN-2:0]};

    assign c_out = hi[1];
    assign v_out = hi[1] ^ lo[XLEN-1];

    always_comb begin
        unique case (op)
            conjunction_op, mask_test_op:          res = a & b;
            mask_clear_op:                         res = a & ~b;
            bitwise_xor_op, equivalence_test_op:   res = a ^ b;
            bitwise_disjunction_op:                res = a | b;
            copy_op:                               res = b;
            invert_copy_op:                        res = ~b;
            default:                               res = sum_w;
        endcase
    end
endmodule // alu_core
`default_nettype wire

//--- hdl/dp_exec_unit.sv
// Data-processing execution unit with register file and call branch.
// Assumes an AXI4-Lite master; one write and one read at a time.
`timescale 1ns/1ps
`default_nettype none
module dp_exec_unit import dp_pkg::*; (
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic          ce,
    input  wire logic          awvalid,
    output logic               awready,
    input  wire logic [AW-1:0] awaddr,
    input  wire logic          wvalid,
    output logic               wready,
    input  wire logic [31:0]   wdata,
    input  wire logic [3:0]    wstrb,
    output logic               bvalid,
    input  wire logic          bready,
    output logic [1:0]         bresp,
    input  wire logic          arvalid,
    output logic               arready,
    input  wire logic [AW-1:0] araddr,
    output logic               rvalid,
    input  wire logic          rready,
    output logic [31:0]        rdata,
    output logic [1:0]         rresp
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        wr_collect = 3'b001,
        wr_exec    = 3'b010,
        wr_resp    = 3'b100
    } wr_state_t;

    wr_state_t       wr_q;
    wr_state_t       wr_d;
    logic            awready_q;
    logic            wready_q;
    logic            bvalid_q;
    logic [1:0]      bresp_q;
    logic [AW-1:0]   waddr_q;
    logic [31:0]     wdata_q;
    logic [3:0]      wstrb_q;
    logic            arready_q;
    logic            rvalid_q;
    logic [31:0]     rdata_q;
    logic [1:0]      rresp_q;
    logic [XLEN-1:0] gpr_q [NREG];
    logic [XLEN-1:0] gpr_d [NREG];
    logic [31:0]     instr_q;
    logic [31:0]     call_q;
    logic [XLEN-1:0] result_q;

    // ----------------------------------------------------------------
    // Write address decode
    // ----------------------------------------------------------------
    wire       w_gpr   = waddr_q[7:6] == GPR_REGION;
    wire       w_instr = waddr_q[7:2] == OFF_INSTR[7:2];
    wire       w_call  = waddr_q[7:2] == OFF_CALL[7:2];
    wire       w_res   = waddr_q[7:2] == OFF_RESULT[7:2];
    wire       w_hit   = w_gpr | w_instr | w_call | w_res;
    wire       in_exec = wr_q == wr_exec;
    wire [3:0] w_idx   = waddr_q[5:2];

    wire       bus_gpr = in_exec & w_gpr;
    wire       do_exec = in_exec & w_instr;
    wire       do_call = in_exec & w_call;

    wire [31:0] instr_w = byte_merge(instr_q, wdata_q, wstrb_q);
    wire [31:0] call_w  = byte_merge(call_q, wdata_q, wstrb_q);
    wire [31:0] gpr_w   = byte_merge(gpr_q[w_idx], wdata_q, wstrb_q);
    wire instr_t ins    = instr_t'(instr_w);

    // ----------------------------------------------------------------
    // Operand routing
    // ----------------------------------------------------------------
    wire [XLEN-1:0] pcs   = gpr_q[PCS_IDX];
    wire            mode_user = pcs[1:0] == MODE_USER;

    // Status bits read as zero when pc_status_reg is the first source or count
    function automatic logic [XLEN-1:0] src_val(input logic [3:0] idx,
                                                 input logic [XLEN-1:0] v);
        return (idx == PCS_IDX) ? (v & PC_MASK) : v;
    endfunction

    wire [XLEN-1:0] rn_val = src_val(ins.rn, gpr_q[ins.rn]);
    wire [XLEN-1:0] rs_val = src_val(ins.amt[3:0], gpr_q[ins.amt[3:0]]);
    wire [7:0]      rs_byt = rs_val[7:0];
    // Second operand keeps its status bits
    wire [XLEN-1:0] sh_val = ins.imm_form ? {24'h0, ins.amt}
                                          : gpr_q[ins.rm];
    wire [7:0]      sh_amt = ins.imm_form ? {3'h0, ins.rm, 1'b0}
                           : ins.amt_reg  ? rs_byt : ins.amt;
    wire sh_kind_t  sh_knd = ins.imm_form ? sh_ror : ins.sh;
    wire            sh_rrx = !ins.imm_form && !ins.amt_reg
                             && ins.sh == sh_ror && ins.amt == 8'h00;

    logic [XLEN-1:0] sh_res;
    logic            sh_c;
    logic [XLEN-1:0] alu_res;
    logic            alu_c;
    logic            alu_v;

    barrel_shift u_shift (
        .val  (sh_val),
        .kind (sh_knd),
        .amt  (sh_amt),
        .rrx  (sh_rrx),
        .cin  (pcs[FLAG_C]),
        .res  (sh_res),
        .cout (sh_c)
    );

    alu_core u_alu (
        .op    (ins.op),
        .a     (rn_val),
        .b     (sh_res),
        .cin   (pcs[FLAG_C]),
        .res   (alu_res),
        .c_out (alu_c),
        .v_out (alu_v)
    );

    // ----------------------------------------------------------------
    // Flag and destination update
    // ----------------------------------------------------------------
    wire arith    = op_is_arith(ins.op);
    wire has_dest = op_has_dest(ins.op);
    wire to_pcs   = has_dest && ins.rd == PCS_IDX;

    wire new_c = arith ? alu_c : sh_c;
    wire new_v = arith ? alu_v : pcs[FLAG_V];
    wire [3:0] new_nzcv = {alu_res[XLEN-1], alu_res == '0, new_c, new_v};

    wire flag_wr = do_exec && ins.set_flags && !to_pcs;

    wire [XLEN-1:0] pcs_mask = !ins.set_flags ? PC_MASK
                             : mode_user      ? USER_MASK : '1;
    wire [XLEN-1:0] pcs_copy = (pcs & ~pcs_mask) | (alu_res & pcs_mask);

    wire [XLEN-1:0] link_val = pcs - LINK_STEP;
    wire [PC_MSB-PC_LSB:0] pc_tgt = pcs[PC_MSB:PC_LSB]
                                    + call_w[PC_MSB-PC_LSB:0];

    always_comb begin
        for (int i = 0; i < NREG; i++) begin
            gpr_d[i] = gpr_q[i];
        end
        if (bus_gpr) begin
            gpr_d[w_idx] = gpr_w;
        end
        if (flag_wr) begin
            gpr_d[PCS_IDX][FLAG_N:FLAG_V] = new_nzcv;
        end
        if (do_exec && has_dest) begin
            gpr_d[ins.rd] = to_pcs ? pcs_copy : alu_res;
        end
        if (do_call) begin
            gpr_d[LINK_IDX]              = link_val;
            gpr_d[PCS_IDX][PC_MSB:PC_LSB] = pc_tgt;
        end
    end

    // ----------------------------------------------------------------
    // Write channel sequencing
    // ----------------------------------------------------------------
    wire aw_fire = awvalid && awready_q;
    wire w_fire  = wvalid && wready_q;
    wire aw_ok   = !awready_q || awvalid;
    wire w_ok    = !wready_q || wvalid;

    always_comb begin
        wr_d = wr_q;
        unique case (wr_q)
            wr_collect: if (aw_ok && w_ok) wr_d = wr_exec;
            wr_exec:    wr_d = wr_resp;
            wr_resp:    if (bready) wr_d = wr_collect;
            default:    wr_d = wr_collect;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_q      <= wr_collect;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            waddr_q   <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
        end else if (ce) begin
            wr_q <= wr_d;
            if (aw_fire) begin
                waddr_q   <= awaddr;
                awready_q <= 1'b0;
            end
            if (w_fire) begin
                wdata_q  <= wdata;
                wstrb_q  <= wstrb;
                wready_q <= 1'b0;
            end
            if (in_exec) begin
                bvalid_q <= 1'b1;
                bresp_q  <= w_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (wr_q == wr_resp && bready) begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    // Result register is read-only; writes answer OKAY but change nothing
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            instr_q  <= '0;
            call_q   <= '0;
            result_q <= '0;
            for (int i = 0; i < NREG; i++) begin
                gpr_q[i] <= '0;
            end
        end else if (ce) begin
            gpr_q <= gpr_d;
            if (do_exec) begin
                instr_q  <= instr_w;
                result_q <= alu_res;
            end
            if (do_call) begin
                call_q <= call_w;
            end
        end
    end

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    wire        r_gpr = araddr[7:6] == GPR_REGION;
    wire        r_ins = araddr[7:2] == OFF_INSTR[7:2];
    wire        r_cal = araddr[7:2] == OFF_CALL[7:2];
    wire        r_res = araddr[7:2] == OFF_RESULT[7:2];
    wire        r_hit = r_gpr | r_ins | r_cal | r_res;
    wire [31:0] r_val = r_gpr ? gpr_q[araddr[5:2]]
                      : r_ins ? instr_q
                      : r_cal ? call_q
                      : r_res ? result_q : '0;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= RESP_OKAY;
        end else if (ce) begin
            if (arvalid && arready_q) begin
                arready_q <= 1'b0;
                rvalid_q  <= 1'b1;
                rdata_q   <= r_val;
                rresp_q   <= r_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_q && rready) begin
                arready_q <= 1'b1;
                rvalid_q  <= 1'b0;
            end
        end
    end

    assign awready = awready_q;
    assign wready  = wready_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    assign arready = arready_q;
    assign rvalid  = rvalid_q;
    assign rdata   = rdata_q;
    assign rresp   = rresp_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    wire ex  = ce && do_exec;
    wire exd = ex && !to_pcs && has_dest;

    a_link_value: assert property ( // Return address
        ce && do_call |=> gpr_q[LINK_IDX] == $past(pcs) - LINK_STEP)
        else $error("link value wrong");
    a_plain_copy: assert property ( // Status kept
        ex && to_pcs && !ins.set_flags
        |=> (pcs & ~PC_MASK) == ($past(pcs) & ~PC_MASK))
        else $error("plain copy touched status");
    a_flags_hold: assert property ( // No update
        ex && !ins.set_flags && !to_pcs |=> pcs == $past(pcs))
        else $error("flags changed without update");
    a_invert_val: assert property ( // Complement
        exd && ins.op == invert_copy_op
        |=> gpr_q[$past(ins.rd)] == ~$past(sh_res))
        else $error("invert copy wrong");
    a_logic_flags: assert property ( // Carry and overflow
        ex && ins.set_flags && !arith && !to_pcs
        |=> pcs[FLAG_V] == $past(pcs[FLAG_V])
            && pcs[FLAG_C] == $past(sh_c))
        else $error("logic flags wrong");
    a_nz_track: assert property ( // Result flags
        exd && ins.set_flags |=> pcs[FLAG_N] == $past(alu_res[XLEN-1])
            && pcs[FLAG_Z] == ($past(alu_res) == '0))
        else $error("n or z wrong");
    a_sum_value: assert property ( // Sum
        exd && ins.op == sum_op
        |=> gpr_q[$past(ins.rd)] == $past(rn_val) + $past(sh_res))
        else $error("sum wrong");
    a_sub_carry: assert property ( // No underflow
        ex && ins.set_flags && ins.op == compare_op
        |=> pcs[FLAG_C] == ($past(rn_val) >= $past(sh_res)))
        else $error("compare carry wrong");
    a_sum_ovf: assert property ( // Signed overflow
        exd && ins.set_flags && ins.op == sum_op
        |=> pcs[FLAG_V] == ($past(rn_val[XLEN-1]) == $past(sh_res[XLEN-1])
            && $past(alu_res[XLEN-1]) != $past(rn_val[XLEN-1])))
        else $error("overflow wrong");
    a_lsl_carry: assert property ( // Shift carry
        !sh_rrx && sh_knd == sh_lsl && sh_amt > 8'h20 |-> !sh_c)
        else $error("lsl carry not zero");
    a_bresp_hold: assert property (
        bvalid_q && !bready |=> bvalid_q && $stable(bresp_q))
        else $error("write response dropped");

    c_call: cover property (ce && do_call);
    c_pcs_restore: cover property (ex && to_pcs && ins.set_flags);
    c_slverr: cover property (bvalid_q && bresp_q == RESP_SLVERR);

endmodule // dp_exec_unit
`default_nettype wire

//--- tb/instr_src.sv
// Instruction producer model: encodes data-processing words.
// Assumes the word layout of instr_t in the shared package.
`timescale 1ns/1ps
`default_nettype none
module instr_src import dp_pkg::*;;
    // ------
    // Encoder
    // ------
    function automatic logic [31:0] enc(input alu_op_t op,
        input logic s, input logic [3:0] rd, input logic [3:0] rn,
        input logic [3:0] rm, input logic [7:0] amt);
        instr_t w;
        w = '0;
        w.op = op;
        w.set_flags = s | (op inside {compare_op, compare_negated_op,
                                      equivalence_test_op, mask_test_op});
        w.rd = rd;
        w.rn = rn;
        w.rm = rm;
        w.amt = amt;
        return w;
    endfunction
    // Shift kind, count source and immediate form
    function automatic logic [31:0] shape(input logic [31:0] word,
        input sh_kind_t sh, input logic by_reg, input logic imm);
        instr_t w;
        w = instr_t'(word);
        w.sh = sh;
        w.amt_reg = by_reg;
        w.imm_form = imm;
        return w;
    endfunction
endmodule // instr_src
`default_nettype wire

//--- tb/tb.sv
// Bench for the execution unit: bus tasks and scenarios.
// Assumes the producer model encodes every instruction word.
`timescale 1ns/1ps
`default_nettype none
module tb import dp_pkg::*;;
    logic        clk = 0, rstn = 0, ce = 1, bvalid, rvalid;
    logic        awvalid = 0, wvalid = 0, bready = 0, awready, wready;
    logic        arvalid = 0, rready = 0, arready;
    logic [7:0]  awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0]  wstrb = 4'hf;
    logic [1:0]  bresp, rresp, wresp;
    int          error_cnt = 0, total_checks = 0;
    always #2 clk = ~clk;
    instr_src src();
    dp_exec_unit dut(
        .clk(clk), .rstn(rstn), .ce(ce),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp)
    );
    // ------
    // Bus and compare tasks
    // ------
    task automatic chk(input string n, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        wresp = bresp;
        bready <= 1'h0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
        @(posedge clk);
    endtask
    task automatic op(input alu_op_t o, input logic s,
        input logic [3:0] d, n, m, input logic [7:0] a,
        input logic [31:0] ev, input logic [3:0] ef,
        input logic [3:0] x = 4'h0);
        logic [31:0] v;
        logic [1:0]  r;
        wr(8'h40, src.shape(src.enc(o, s, d, n, m, a),
                            sh_kind_t'(x[3:2]), x[1], x[0]));
        rd({2'h0, d, 2'h0}, v, r);
        chk("result", ev, v);
        rd(8'h3c, v, r);
        chk("flags", {28'h0, ef}, {28'h0, v[31:28]});
    endtask
    // ------
    // Scenarios
    // ------
    task automatic t_alu;
        wr(8'h04, 32'h7fffffff);
        wr(8'h08, 32'h00000001);
        op(sum_op,1'h1,4'h3,4'h1,4'h2,8'h0,32'h80000000,4'h9);
        op(minus_with_borrow_op,1'h1,4'h4,4'h1,4'h2,8'h0,
           32'h7ffffffd,4'h2);
        op(copy_op,1'h1,4'h5,4'h0,4'h1,8'h2,32'hfffffffc,4'ha);
        op(sum_op,1'h0,4'h6,4'h2,4'h2,8'h0,32'h00000002,4'ha);
        op(bitwise_xor_op,1'h1,4'h7,4'h1,4'h1,8'h0,32'h0,4'h6);
    endtask
    task automatic t_ops;
        op(sum_carry_op,1'h1,4'h8,4'h2,4'h2,8'h0,32'h3,4'h0);
        op(minus_op,1'h1,4'h9,4'h2,4'h1,8'h0,32'h80000002,4'h8);
        op(reversed_minus_borrow_op,1'h1,4'hb,4'h2,4'h6,8'h0,
           32'h0,4'h6);
        op(reversed_minus_op,1'h1,4'ha,4'h2,4'h6,8'h0,32'h1,4'h2);
        op(conjunction_op,1'h1,4'hc,4'h5,4'h1,8'h0,32'h7ffffffc,
           4'h2);
        op(mask_clear_op,1'h1,4'hd,4'h5,4'h1,8'h0,32'h80000000,
           4'ha);
        op(bitwise_disjunction_op,1'h1,4'h8,4'h2,4'h3,8'h1f,32'h1,
           4'h0,4'h4);
        op(invert_copy_op,1'h1,4'h9,4'h0,4'h3,8'h21,32'h0,
           4'h6,4'h8);
        op(compare_op,1'h0,4'h7,4'h1,4'h3,8'h0,32'h0,4'h9);
        op(compare_negated_op,1'h0,4'h7,4'h3,4'h3,8'h0,32'h0,
           4'h7);
        op(equivalence_test_op,1'h0,4'h7,4'h1,4'h1,8'h1,32'h0,
           4'h9);
        op(mask_test_op,1'h0,4'h7,4'h5,4'h1,8'hff,32'h0,
           4'hb,4'h1);
        op(copy_op,1'h1,4'h8,4'h0,4'h2,8'h0,32'h80000000,
           4'hb,4'hc);
        op(copy_op,1'h1,4'h8,4'h0,4'h1,8'h21,32'h0,4'h5);
    endtask
    task automatic t_call;
        logic [31:0] v;
        logic [1:0]  r;
        wr(8'h3c, 32'h60000100);
        wr(8'h44, 32'h0);
        rd(8'h38, v, r);
        chk("link", 32'h600000fc, v);
        wr(8'h3c, 32'h00000100);
        op(copy_op,1'h0,4'hf,4'h0,4'he,8'h0,32'h000000fc,4'h0);
        op(copy_op,1'h1,4'hf,4'h0,4'he,8'h0,32'h600000fc,4'h6);
    endtask
    task automatic t_bad;
        logic [31:0] v;
        logic [1:0]  r;
        rd(8'h80, v, r);
        chk("resp", 32'h2, {30'h0, r});
        chk("rdata", 32'h0, v);
        wr(8'h80, 32'h1);
        chk("bresp", 32'h2, {30'h0, wresp});
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'h1;
        @(posedge clk);
        t_alu();
        t_ops();
        t_call();
        t_bad();
        stop_test();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        #(4 * 5000);
        error_cnt++;
        stop_test();
    end
endmodule // tb
`default_nettype wire
